/* hw/pwm_measure.sv */
// pulse width measurement top module
module pwm_measure #(
  parameter int unsigned TICK_CYC = pwm_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire pwm_pkg::pwm_cmd_t cmd_i,
  input wire logic [pwm_pkg::NUM_PINS-1:0] pins_i,
  output logic busy_o,
  output pwm_pkg::pwm_rsp_t rsp_o
);
  typedef enum logic [2:0] {
    PWM_IDLE = 3'b001,
    PWM_WAIT = 3'b010,
    PWM_TIME = 3'b100
  } pwm_state_t;

  pwm_state_t state;
  pwm_pkg::pwm_cmd_t cmd;
  logic sel;
  logic sel_q;
  logic tick;
  logic tick_clr;
  logic [pwm_pkg::RESULT_W-1:0] width;
  logic [pwm_pkg::RESULT_W-1:0] tmo;
  logic start_edge;
  logic end_edge;

  // R1 pin select
  assign sel = pins_i[cmd.pin];
  // R2 start polarity
  assign start_edge = cmd.polarity ? (sel & ~sel_q) : (~sel & sel_q);
  // R7 opposite edge
  assign end_edge = cmd.polarity ? (~sel & sel_q) : (sel & ~sel_q);
  assign tick_clr = (state == PWM_IDLE);

  pwm_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clear_i(tick_clr),
    .tick_o(tick)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cmd <= '0;
      sel_q <= 1'b0;
    end else begin
      if (state == PWM_IDLE && start_i) begin
        cmd <= cmd_i;
        sel_q <= pins_i[cmd_i.pin];
      end else begin
        sel_q <= sel;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state <= PWM_IDLE;
      width <= pwm_pkg::RESULT_RST;
      tmo <= pwm_pkg::RESULT_RST;
      busy_o <= 1'b0;
      rsp_o <= '0;
    end else begin
      rsp_o.done <= 1'b0;
      unique case (state)
        PWM_IDLE: begin
          if (start_i) begin
            state <= PWM_WAIT;
            busy_o <= 1'b1;
            width <= pwm_pkg::RESULT_RST;
            tmo <= pwm_pkg::RESULT_RST;
          end
        end
        PWM_WAIT, PWM_TIME: begin
          // R5 R6 timeout after 65536 ticks
          if (tick && tmo == pwm_pkg::RESULT_MAX) begin
            state <= PWM_IDLE;
            busy_o <= 1'b0;
            rsp_o.done <= 1'b1;
            rsp_o.width <= pwm_pkg::RESULT_RST;
          end else if (state == PWM_WAIT) begin
            if (tick) tmo <= tmo + 16'h0001;
            if (start_edge) state <= PWM_TIME;
          end else if (end_edge) begin
            // R7 R4 result capture, at least one
            state <= PWM_IDLE;
            busy_o <= 1'b0;
            rsp_o.done <= 1'b1;
            rsp_o.width <= (width == pwm_pkg::RESULT_RST) ? 16'h0001 : width;
          end else if (tick) begin
            // R3 tick count
            tmo <= tmo + 16'h0001;
            if (width != pwm_pkg::RESULT_MAX) width <= width + 16'h0001;
          end
        end
      endcase
    end
  end
endmodule : pwm_measure

/* hw/pwm_pkg.sv */
// package for the pulse width measure block
// Contract
// R1: select one of eight input pins by a 3-bit number, measure only it
// R2: polarity 1 starts on rising edge, polarity 0 on falling edge
// R3: width counter advances once per 10us at 4MHz clock
// R4: completed result is a 16-bit word from 1 to 65535 ticks
// R5: no pulse within timeout of 0.65536s at 4MHz returns zero
// R6: tick and timeout scale with clock: 5us/0.32768s at 8MHz, 2.5us/0.16384s at 16MHz
// R7: timing stops at first opposite edge; counter value then is the result
package pwm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // tick unit in nanoseconds at the 4MHz reference resonator
  localparam int unsigned TICK_REF_NS = 10_000;
  localparam int unsigned REF_HZ = 4_000_000;
  // resonator frequency in MHz selects the unit: 4, 8 or 16
  localparam int unsigned RES_MHZ = 4;
  localparam int unsigned TICK_NS = (TICK_REF_NS * (REF_HZ / 1_000_000)) / RES_MHZ;
  localparam int unsigned TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned PIN_W = 3;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 16'hFFFF;

  typedef struct packed {
    logic [PIN_W-1:0] pin;
    logic polarity;
  } pwm_cmd_t;

  typedef struct packed {
    logic done;
    logic [RESULT_W-1:0] width;
  } pwm_rsp_t;
endpackage : pwm_pkg

/* hw/pwm_tick.sv */
// tick prescaler producing one pulse per time unit
module pwm_tick #(
  parameter int unsigned TICK_CYC = pwm_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  output logic tick_o
);
  localparam int unsigned CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || clear_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end
endmodule : pwm_tick

/* tb/pwm_checker.sv */
// port assertions for the pulse width measure block
module pwm_checker (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire pwm_pkg::pwm_cmd_t cmd_i,
  input wire logic [7:0] pins_i,
  input wire logic busy_o,
  input wire pwm_pkg::pwm_rsp_t rsp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence taken_s;
    start_i && !busy_o;
  endsequence
  start_busy_a: assert property (taken_s |=> busy_o) else $error("no busy");
  done_pulse_a: assert property (rsp_o.done |=> !rsp_o.done) else $error("long done");
  done_free_a: assert property (rsp_o.done && !start_i |=> !busy_o) else $error("busy");
  width_hold_a: assert property (!rsp_o.done |-> $stable(rsp_o.width)) else $error("w");
  done_idle_a: assert property (rsp_o.done |-> !busy_o) else $error("busy at done");
  busy_start_a: assert property ($rose(busy_o) |-> $past(start_i)) else $error("no start");
  idle_quiet_a: assert property (!busy_o && !rsp_o.done |=> !rsp_o.done) else $error("done idle");
endmodule : pwm_checker
bind pwm_measure pwm_checker pwm_checker_inst (.*);

/* tb/pwm_src.sv */
// pulse source on the eight inputs
module pwm_src (
  input wire logic sys_clk_i,
  output logic [7:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins_o = 8'h00;
  task automatic pulse(input int p, input logic q, input int ln);
    pins_o[p] = q;
    repeat (ln) @(posedge sys_clk_i);
    #1 pins_o[p] = ~q;
  endtask : pulse
endmodule : pwm_src

/* tb/tb.sv */
// testbench of the pulse width measure block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, resetn_i = 0, start_i = 0, busy_o;
  logic [7:0] pins_i;
  pwm_pkg::pwm_cmd_t cmd_i = '0;
  pwm_pkg::pwm_rsp_t rsp_o;
  int num_errors = 0, n_tests = 0, cyc = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  pwm_src pwm_src_inst (.sys_clk_i(sys_clk_i), .pins_o(pins_i));
  pwm_measure #(.TICK_CYC(1)) pwm_measure_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .start_i(start_i), .cmd_i(cmd_i), .pins_i(pins_i), .busy_o(busy_o), .rsp_o(rsp_o));
  task automatic conclude;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk_i) if (++cyc > 90000) begin
    num_errors++;
    conclude();
  end
  // one-bit result against its expected level
  task automatic check_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : check_flag
  // width result against an inclusive window
  task automatic check_width(input logic [15:0] got, input int lo, input int hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, lo[15:0]);
      num_errors++;
    end
  endtask : check_width
  // one measurement with an optional decoy pulse on pin fp
  task automatic meas(input logic [2:0] p, input logic q, input int ln, input int fp);
    int n;
    n = 0;
    pwm_src_inst.pins_o = {8{~q}};
    @(posedge sys_clk_i);
    #1 start_i = 1;
    cmd_i = '{p, q};
    @(posedge sys_clk_i);
    #1 start_i = 0;
    check_flag(busy_o, 1'b1);
    if (fp < 8) pwm_src_inst.pulse(fp, q, 3);
    if (ln > 0) pwm_src_inst.pulse(p, q, ln);
    while (rsp_o.done !== 1'b1 && n < 70000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    check_flag(rsp_o.done, 1'b1);
    check_flag(busy_o, 1'b0);
    if (ln == 0) check_width(rsp_o.width, 0, 0);
    else check_width(rsp_o.width, (ln > 2) ? ln - 2 : 1, ln + 2);
  endtask : meas
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 resetn_i = 1;
    meas(3'h3, 1'b1, 20, 5);
    meas(3'h5, 1'b0, 7, 2);
    meas(3'h0, 1'b1, 1, 8);
    meas(3'h7, 1'b0, 0, 8);
    conclude();
  end
endmodule : tb
